// ==== src/bet_pkg.sv ====
package bet_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0]  ADDR_CTRL     = 8'h00;
    localparam logic [7:0]  ADDR_PATTERN  = 8'h04;
    localparam logic [7:0]  ADDR_SEED     = 8'h08;
    localparam logic [7:0]  ADDR_STATUS   = 8'h0C;
    localparam logic [7:0]  ADDR_BITCNT   = 8'h10;
    localparam logic [7:0]  ADDR_ERRCNT   = 8'h14;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int          CTRL_ENABLE   = 0;
    localparam int          CTRL_QRSS     = 1;
    localparam int          CTRL_REPEAT   = 2;
    localparam int          CTRL_NORESYNC = 3;
    localparam int          CTRL_TXLOAD   = 4;
    localparam int          CTRL_RXLOAD   = 5;
    localparam int          CTRL_SINGLE   = 6;
    localparam int          CTRL_PINSRC   = 7;
    localparam int          CTRL_INVERT   = 8;
    localparam int          CTRL_PMU      = 9;
    localparam int          CTRL_RATE_LO  = 12;
    localparam int          CTRL_RATE_HI  = 14;
    localparam logic [31:0] CTRL_MASK     = 32'h0000_73FF;

    // Pattern register: length field n-1 in [4:0], tap field y-1 in [12:8]
    localparam int          PAT_LEN_LO    = 0;
    localparam int          PAT_LEN_HI    = 4;
    localparam int          PAT_TAP_LO    = 8;
    localparam int          PAT_TAP_HI    = 12;
    localparam logic [31:0] PAT_MASK      = 32'h0000_1F1F;

    // Status register fields
    localparam int          STAT_ERRSEEN  = 0;
    localparam int          STAT_UNLOCK   = 1;

    // ------------------------------------------------------------
    // Generator and sync constants
    // ------------------------------------------------------------
    localparam int          GEN_W         = 32;
    localparam int          QRSS_TAP_A    = 16;
    localparam int          QRSS_TAP_B    = 19;
    localparam int          QRSS_RUN      = 14;
    localparam logic [5:0]  SYNC_BITS     = 6'd32;
    localparam logic [5:0]  WIN_LAST      = 6'd63;
    localparam logic [2:0]  WIN_ERR_LIMIT = 3'd6;
    localparam int          BITCNT_W      = 32;
    localparam int          ERRCNT_W      = 24;
    localparam int          RATE_W        = 24;

    // Bits between rate errors, indexed by rate field n (0 is off)
    localparam logic [RATE_W-1:0] RATE_TABLE [8] = '{
        24'd0, 24'd10, 24'd100, 24'd1000, 24'd10000,
        24'd100000, 24'd1000000, 24'd10000000
    };

    typedef enum logic [1:0] {
        BET_LOAD,
        BET_VERIFY,
        BET_SYNC
    } bet_sync_t;

endpackage

// ==== src/bet_core.sv ====
`timescale 1ns/1ns
// Overview of operation
// - Receive side checks payload bits only
// - Receive generator: 32-bit shift, feedback into bit1
// - Feedback: n xor y, or bit n repetitive
// - Generator output equals its feedback bit
// - QRSS: taps 17,20; output high after 14 zeros
// - PRBS feedback forced one when bits 1-31 zero; repetitive feedback not forced
// - PRBS sync: load 32, verify 32 matches
// - Repetitive sync: search pattern, verify 32 bits
// - Six errors in 64-bit window resync
// - Automatic resync can be disabled
// - Unlocked flag set outside sync state
// - Compare bits; count bits and errors
// - Counters frozen while unlocked
// - Transmit generator mirrors receive generator
// - New pattern load presets transmit seed
// - Single errors or one per 10^n bits
// - Single error from register or pin
// - Optional inversion of outgoing test stream
// - Pattern loads act on rising control edge
// - Monitor update latches and clears counters
// - Error counter 24 bits, bit counter 32
// - Errors seen flag when error count nonzero
module bet_core
    import bet_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        tx_bit_en,
    output logic             tx_data,
    input  wire logic        rx_bit_en,
    input  wire logic        rx_data,
    input  wire logic        manual_error_insert_pin,
    output logic             pattern_unlocked_flag,
    output logic             errors_seen_flag
);

    // ------------------------------------------------------------
    // Generator feedback
    // ------------------------------------------------------------
    function automatic logic gen_fb(input logic [GEN_W-1:0] s, input logic [4:0] n,
                                    input logic [4:0] y, input logic qrss, input logic rep);
        logic f;
        f = 1'b0;
        if (rep) begin
            f = s[n];
        end else begin
            if (qrss) begin
                f = s[QRSS_TAP_A] ^ s[QRSS_TAP_B];
            end else begin
                f = s[n] ^ s[y];
            end
            if (s[GEN_W-2:0] == '0) begin
                f = 1'b1;
            end
        end
        return f;
    endfunction

    // Output bit is the feedback, forced high by the QRSS zero run
    function automatic logic gen_out(input logic [GEN_W-1:0] s, input logic fb,
                                     input logic qrss, input logic rep);
        logic o;
        o = fb;
        if (qrss && !rep && s[QRSS_RUN-1:0] == '0) begin
            o = 1'b1;
        end
        return o;
    endfunction

    function automatic logic [GEN_W-1:0] len_mask(input logic [4:0] n);
        logic [GEN_W-1:0] m;
        m = '0;
        for (int i = 0; i < GEN_W; i++) begin
            m[i] = (5'(i) <= n);
        end
        return m;
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [31:0]          ctrl_q, ctrl_d;
    logic [31:0]          pat_q, pat_d;
    logic [31:0]          seed_q, seed_d;
    logic [31:0]          prdata_q, prdata_d;
    logic                 pready_q, pready_d;
    logic                 pslverr_q, pslverr_d;
    logic [31:0]          ctrl_prev_q, ctrl_prev_d;
    logic [1:0]           pin_sync_q, pin_sync_d;
    logic                 pin_prev_q, pin_prev_d;
    logic [GEN_W-1:0]     tx_gen_q, tx_gen_d;
    logic                 tx_data_q, tx_data_d;
    logic                 err_pend_q, err_pend_d;
    logic [RATE_W-1:0]    rate_cnt_q, rate_cnt_d;
    logic [GEN_W-1:0]     rx_gen_q, rx_gen_d;
    bet_sync_t            sync_q, sync_d;
    logic [5:0]           cnt_q, cnt_d;
    logic [5:0]           win_q, win_d;
    logic [2:0]           win_err_q, win_err_d;
    logic [BITCNT_W-1:0]  bitcnt_q, bitcnt_d;
    logic [ERRCNT_W-1:0]  errcnt_q, errcnt_d;
    logic [BITCNT_W-1:0]  bitreg_q, bitreg_d;
    logic [ERRCNT_W-1:0]  errreg_q, errreg_d;

    logic                 enable;
    logic                 qrss;
    logic                 rep;
    logic [4:0]           len_n;
    logic [4:0]           tap_y;
    logic [2:0]           rate_n;
    logic [31:0]          rise;
    logic                 wr_en;
    logic                 rd_en;
    logic                 tx_fb;
    logic                 tx_out;
    logic                 rx_fb;
    logic                 rx_out;
    logic                 rx_bit;
    logic                 mism;
    logic                 pin_edge;
    logic                 rate_hit;

    assign enable   = ctrl_q[CTRL_ENABLE];
    assign qrss     = ctrl_q[CTRL_QRSS];
    assign rep      = ctrl_q[CTRL_REPEAT];
    assign len_n    = pat_q[PAT_LEN_HI:PAT_LEN_LO];
    assign tap_y    = pat_q[PAT_TAP_HI:PAT_TAP_LO];
    assign rate_n   = ctrl_q[CTRL_RATE_HI:CTRL_RATE_LO];
    assign rise     = ctrl_q & ~ctrl_prev_q;
    assign wr_en    = psel && penable && pwrite && pready_q;
    assign rd_en    = psel && penable && !pwrite && !pready_q;
    assign pin_edge = pin_sync_q[1] && !pin_prev_q;

    assign tx_fb    = gen_fb(tx_gen_q, len_n, tap_y, qrss, rep);
    assign tx_out   = gen_out(tx_gen_q, tx_fb, qrss, rep);
    assign rx_fb    = gen_fb(rx_gen_q, len_n, tap_y, qrss, rep);
    assign rx_out   = gen_out(rx_gen_q, rx_fb, qrss, rep);
    assign rx_bit   = enable && rx_bit_en;
    assign mism     = rx_data != rx_out;
    assign rate_hit = (rate_n != '0) && (rate_cnt_q == RATE_TABLE[rate_n] - 24'd1);

    // ------------------------------------------------------------
    // APB slave and register file
    // ------------------------------------------------------------
    always_comb begin
        ctrl_d      = ctrl_q;
        pat_d       = pat_q;
        seed_d      = seed_q;
        prdata_d    = prdata_q;
        pslverr_d   = 1'b0;
        pready_d    = psel && penable && !pready_q;
        ctrl_prev_d = ctrl_q;
        if (rd_en) begin
            prdata_d = '0;
            case (paddr)
                ADDR_CTRL:    prdata_d = ctrl_q;
                ADDR_PATTERN: prdata_d = pat_q;
                ADDR_SEED:    prdata_d = seed_q;
                ADDR_STATUS: begin
                    prdata_d[STAT_ERRSEEN] = errors_seen_flag;
                    prdata_d[STAT_UNLOCK]  = pattern_unlocked_flag;
                end
                ADDR_BITCNT:  prdata_d = bitreg_q;
                ADDR_ERRCNT:  prdata_d = {8'h00, errreg_q};
                default:      pslverr_d = 1'b1;
            endcase
        end
        if (psel && penable && pwrite && !pready_q) begin
            case (paddr)
                ADDR_CTRL, ADDR_PATTERN, ADDR_SEED: pslverr_d = 1'b0;
                default:                            pslverr_d = 1'b1;
            endcase
        end
        if (wr_en) begin
            case (paddr)
                ADDR_CTRL:    ctrl_d = pwdata & CTRL_MASK;
                ADDR_PATTERN: pat_d  = pwdata & PAT_MASK;
                ADDR_SEED:    seed_d = pwdata;
                default:      ctrl_d = ctrl_q;
            endcase
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q && pready_q;

    // ------------------------------------------------------------
    // Transmit generator and error insertion
    // ------------------------------------------------------------
    always_comb begin
        pin_sync_d = {pin_sync_q[0], manual_error_insert_pin};
        pin_prev_d = pin_sync_q[1];
        tx_gen_d   = tx_gen_q;
        tx_data_d  = tx_data_q;
        rate_cnt_d = rate_cnt_q;
        err_pend_d = err_pend_q;
        if (rise[CTRL_TXLOAD]) begin
            tx_gen_d   = seed_q & len_mask(len_n);
            rate_cnt_d = '0;
        end else if (enable && tx_bit_en) begin
            tx_gen_d  = {tx_gen_q[GEN_W-2:0], tx_fb};
            tx_data_d = tx_out ^ err_pend_q ^ rate_hit ^ ctrl_q[CTRL_INVERT];
            err_pend_d = 1'b0;
            if (rate_n == '0 || rate_hit) begin
                rate_cnt_d = '0;
            end else begin
                rate_cnt_d = rate_cnt_q + 24'd1;
            end
        end
        // A request in a bit slot stays pending for the next slot
        if (ctrl_q[CTRL_PINSRC] ? pin_edge : rise[CTRL_SINGLE]) begin
            err_pend_d = 1'b1;
        end
    end

    assign tx_data = tx_data_q;

    // ------------------------------------------------------------
    // Receive synchronisation
    // ------------------------------------------------------------
    always_comb begin
        rx_gen_d  = rx_gen_q;
        sync_d    = sync_q;
        cnt_d     = cnt_q;
        win_d     = win_q;
        win_err_d = win_err_q;
        if (rise[CTRL_RXLOAD]) begin
            sync_d = BET_LOAD;
            cnt_d  = '0;
        end else if (rx_bit) begin
            case (sync_q)
                BET_LOAD: begin
                    rx_gen_d = {rx_gen_q[GEN_W-2:0], rx_data};
                    cnt_d    = cnt_q + 6'd1;
                    if (rep) begin
                        if ((rx_gen_d & len_mask(len_n)) == (seed_q & len_mask(len_n))) begin
                            sync_d = BET_VERIFY;
                            cnt_d  = '0;
                        end
                    end else if (cnt_q == SYNC_BITS - 6'd1) begin
                        sync_d = BET_VERIFY;
                        cnt_d  = '0;
                    end
                end
                BET_VERIFY: begin
                    rx_gen_d = {rx_gen_q[GEN_W-2:0], rx_fb};
                    cnt_d    = cnt_q + 6'd1;
                    if (mism) begin
                        sync_d = BET_LOAD;
                        cnt_d  = '0;
                    end else if (cnt_q == SYNC_BITS - 6'd1) begin
                        sync_d    = BET_SYNC;
                        win_d     = '0;
                        win_err_d = '0;
                    end
                end
                BET_SYNC: begin
                    rx_gen_d = {rx_gen_q[GEN_W-2:0], rx_fb};
                    win_d    = win_q + 6'd1;
                    if (win_q == WIN_LAST) begin
                        win_err_d = '0;
                    end else if (mism && win_err_q != WIN_ERR_LIMIT) begin
                        win_err_d = win_err_q + 3'd1;
                    end
                    if (mism && win_err_q == WIN_ERR_LIMIT - 3'd1 && !ctrl_q[CTRL_NORESYNC]) begin
                        sync_d = BET_LOAD;
                        cnt_d  = '0;
                    end
                end
                default: begin
                    sync_d = BET_LOAD;
                    cnt_d  = '0;
                end
            endcase
        end
    end

    assign pattern_unlocked_flag = sync_q != BET_SYNC;

    // ------------------------------------------------------------
    // Bit and error counters
    // ------------------------------------------------------------
    always_comb begin
        bitcnt_d = bitcnt_q;
        errcnt_d = errcnt_q;
        bitreg_d = bitreg_q;
        errreg_d = errreg_q;
        if (rise[CTRL_PMU]) begin
            bitreg_d = bitcnt_q;
            errreg_d = errcnt_q;
            bitcnt_d = '0;
            errcnt_d = '0;
        end
        if (rx_bit && sync_q == BET_SYNC) begin
            bitcnt_d = bitcnt_d + 32'd1;
            if (mism) begin
                errcnt_d = errcnt_d + 24'd1;
            end
        end
    end

    assign errors_seen_flag = errcnt_q != '0;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q      <= '0;
            pat_q       <= '0;
            seed_q      <= '0;
            prdata_q    <= '0;
            pready_q    <= 1'b0;
            pslverr_q   <= 1'b0;
            ctrl_prev_q <= '0;
            pin_sync_q  <= '0;
            pin_prev_q  <= 1'b0;
            tx_gen_q    <= '0;
            tx_data_q   <= 1'b0;
            err_pend_q  <= 1'b0;
            rate_cnt_q  <= '0;
            rx_gen_q    <= '0;
            sync_q      <= BET_LOAD;
            cnt_q       <= '0;
            win_q       <= '0;
            win_err_q   <= '0;
            bitcnt_q    <= '0;
            errcnt_q    <= '0;
            bitreg_q    <= '0;
            errreg_q    <= '0;
        end else begin
            ctrl_q      <= ctrl_d;
            pat_q       <= pat_d;
            seed_q      <= seed_d;
            prdata_q    <= prdata_d;
            pready_q    <= pready_d;
            pslverr_q   <= pslverr_d;
            ctrl_prev_q <= ctrl_prev_d;
            pin_sync_q  <= pin_sync_d;
            pin_prev_q  <= pin_prev_d;
            tx_gen_q    <= tx_gen_d;
            tx_data_q   <= tx_data_d;
            err_pend_q  <= err_pend_d;
            rate_cnt_q  <= rate_cnt_d;
            rx_gen_q    <= rx_gen_d;
            sync_q      <= sync_d;
            cnt_q       <= cnt_d;
            win_q       <= win_d;
            win_err_q   <= win_err_d;
            bitcnt_q    <= bitcnt_d;
            errcnt_q    <= errcnt_d;
            bitreg_q    <= bitreg_d;
            errreg_q    <= errreg_d;
        end
    end

endmodule

// ==== tb/bet_core_checker.sv ====
`timescale 1ns/1ns
module bet_core_checker
    import bet_pkg::*;
(
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pwrite,
    input wire logic [7:0] paddr,
    input wire logic       pready,
    input wire logic       tx_bit_en,
    input wire logic       tx_data,
    input wire logic       rx_bit_en,
    input wire logic       pattern_unlocked_flag,
    input wire logic       errors_seen_flag
);
    // ----------------------------------------
    // Receive strobes while unlocked
    // ----------------------------------------
    logic [5:0] ucnt_q;
    logic [5:0] ucnt_d;

    always_comb begin
        ucnt_d = ucnt_q;
        if (!pattern_unlocked_flag) begin
            ucnt_d = 6'h00;
        end else if (rx_bit_en && ucnt_q != 6'h3F) begin
            ucnt_d = ucnt_q + 6'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ucnt_q <= 6'h00;
        end else begin
            ucnt_q <= ucnt_d;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_lock_after_bits: assert property ($fell(pattern_unlocked_flag) |-> ucnt_q >= 6'h1F)
        else $error("lock declared too early");
    a_lock_on_strobe: assert property ($fell(pattern_unlocked_flag) |-> $past(rx_bit_en))
        else $error("lock without receive bit");
    a_unlock_cause: assert property ($rose(pattern_unlocked_flag) |-> $past(rx_bit_en) || $past(pready && pwrite, 2))
        else $error("unlock without cause");
    a_err_in_sync: assert property ($rose(errors_seen_flag) |-> $past(rx_bit_en && !pattern_unlocked_flag))
        else $error("error count moved while unlocked");
    a_err_clear: assert property ($fell(errors_seen_flag) |-> $past(pready && pwrite && paddr == ADDR_CTRL, 2))
        else $error("error flag cleared without update");
    a_err_steady: assert property (!$past(rx_bit_en) && !$past(pready, 2) |-> $stable(errors_seen_flag))
        else $error("error flag changed without cause");
    a_tx_hold: assert property (!$past(tx_bit_en) |-> $stable(tx_data))
        else $error("tx bit changed without slot");
    a_ready_access: assert property (pready |-> psel && penable && $past(psel && penable))
        else $error("pready outside access phase");
endmodule

bind bet_core bet_core_checker u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pready(pready), .tx_bit_en(tx_bit_en), .tx_data(tx_data),
    .rx_bit_en(rx_bit_en), .pattern_unlocked_flag(pattern_unlocked_flag),
    .errors_seen_flag(errors_seen_flag)
);

// ==== tb/bet_line_model.sv ====
`timescale 1ns/1ns
module bet_line_model (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic go,
    input  wire logic flip,
    input  wire logic tx_data,
    output logic      tx_bit_en,
    output logic      rx_bit_en,
    output logic      rx_data
);
    // ----------------------------------------
    // Payload loopback with optional bit flip
    // ----------------------------------------
    logic rx_en_q;
    logic flip_q;
    logic tog_q;

    assign tx_bit_en = go;
    assign rx_bit_en = rx_en_q;
    assign rx_data   = rx_en_q ? (tx_data ^ flip_q) : tog_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_en_q <= 1'b0;
            flip_q  <= 1'b0;
            tog_q   <= 1'b0;
        end else begin
            rx_en_q <= tx_bit_en;
            flip_q  <= flip;
            tog_q   <= ~tog_q;
        end
    end
endmodule

// ==== tb/bet_core_tb.sv ====
`timescale 1ns/1ns
module bet_core_tb
    import bet_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, r, s, cw;
    logic        tx_bit_en, tx_data, rx_bit_en, rx_data, pin, unlk, eflag;
    logic        go, flip, q, rep, e;
    int          n_fail, num_checks, cyc, n, y, d;

    // ----------------------------------------
    // Clock, design and line model
    // ----------------------------------------
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    bet_core dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tx_bit_en(tx_bit_en), .tx_data(tx_data), .rx_bit_en(rx_bit_en), .rx_data(rx_data),
        .manual_error_insert_pin(pin), .pattern_unlocked_flag(unlk), .errors_seen_flag(eflag)
    );

    bet_line_model u_line (
        .pclk(pclk), .presetn(presetn), .go(go), .flip(flip), .tx_data(tx_data),
        .tx_bit_en(tx_bit_en), .rx_bit_en(rx_bit_en), .rx_data(rx_data)
    );

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int t;
        t = 0;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            t++;
        end while (pready !== 1'b1 && t < 16);
        if (t >= 16) n_fail++;
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    function automatic logic [32:0] gen(input logic [31:0] st);
        logic fb;
        fb = rep ? st[n-1] : (q ? st[16] ^ st[19] : st[n-1] ^ st[y-1]);
        if (!rep && st[30:0] == 31'h0) fb = 1'b1;
        return {fb | (q && st[13:0] == 14'h0), st[30:0], fb};
    endfunction

    task automatic txrun(input int k, input int lo, input int hi, input logic iv);
        logic [32:0] g;
        d = 0;
        for (int i = 0; i <= k; i++) begin
            go   <= (i < k);
            flip <= (i >= lo && i < hi);
            @(posedge pclk);
            if (i > 0) begin
                g = gen(s);
                s = g[31:0];
                if ((g[32] ^ iv) !== tx_data) d++;
            end
        end
    endtask

    task automatic conclude();
        if (n_fail == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            conclude();
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {presetn, psel, penable, pwrite, go, flip, pin} = '0;
        paddr  = 8'h00;
        pwdata = 32'h0;
        void'($urandom(32'h3E953F21));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(32'(unlk), 32'h1);
        chk(32'(eflag), 32'h0);
        apb(1'b0, 8'h18, 32'h0);
        chk({31'h0, e}, 32'h1);
        apb(1'b1, ADDR_ERRCNT, 32'hFFFFFFFF);
        chk({31'h0, e}, 32'h1);
        for (int m = 0; m < 3; m++) begin
            q   = (m == 1);
            rep = (m == 2);
            n   = q ? 20 : $urandom_range(32, 2);
            y   = q ? 17 : $urandom_range(n - 1, 1);
            s   = $urandom();
            cw  = 32'h1 | (32'(q) << 1) | (32'(rep) << 2) | (32'(q) << 8);
            apb(1'b1, ADDR_PATTERN, {19'h0, 5'(y - 1), 3'h0, 5'(n - 1)});
            apb(1'b1, ADDR_SEED, s);
            apb(1'b1, ADDR_CTRL, cw);
            apb(1'b1, ADDR_CTRL, cw | 32'h30);
            s &= 32'hFFFFFFFF >> (32 - n);
            txrun(100, 0, 0, q);
            chk(32'(d), 32'h0);
            if (!q) chk(32'(unlk), 32'h0);
        end
        q   = 1'b0;
        rep = 1'b0;
        n   = 15;
        y   = 14;
        s   = 32'h7FFF;
        apb(1'b1, ADDR_PATTERN, 32'h0D0E);
        apb(1'b1, ADDR_SEED, s);
        apb(1'b1, ADDR_CTRL, 32'h1001);
        apb(1'b1, ADDR_CTRL, 32'h1031);
        txrun(55, 0, 0, 1'b0);
        chk(32'(d), 32'h5);
        apb(1'b1, ADDR_CTRL, 32'h1);
        apb(1'b1, ADDR_CTRL, 32'h41);
        txrun(20, 0, 0, 1'b0);
        chk(32'(d), 32'h1);
        apb(1'b1, ADDR_CTRL, 32'h81);
        pin <= 1'b1;
        repeat (3) @(posedge pclk);
        pin <= 1'b0;
        repeat (4) @(posedge pclk);
        txrun(20, 0, 0, 1'b0);
        chk(32'(d), 32'h1);
        s = 32'h7FFF;
        apb(1'b1, ADDR_CTRL, 32'h201);
        apb(1'b1, ADDR_CTRL, 32'h31);
        txrun(100, 80, 83, 1'b0);
        repeat (2) @(posedge pclk);
        chk(32'(unlk), 32'h0);
        chk(32'(eflag), 32'h1);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(r, 32'h1);
        apb(1'b1, ADDR_CTRL, 32'h1);
        apb(1'b1, ADDR_CTRL, 32'h201);
        apb(1'b0, ADDR_BITCNT, 32'h0);
        chk(r, 32'd36);
        apb(1'b0, ADDR_ERRCNT, 32'h0);
        chk(r, 32'd3);
        chk(32'(eflag), 32'h0);
        apb(1'b1, ADDR_CTRL, 32'h9);
        txrun(40, 10, 21, 1'b0);
        repeat (2) @(posedge pclk);
        chk(32'(unlk), 32'h0);
        apb(1'b1, ADDR_CTRL, 32'h1);
        txrun(40, 10, 21, 1'b0);
        repeat (2) @(posedge pclk);
        chk(32'(unlk), 32'h1);
        conclude();
    end
endmodule
